// file: hw/sbio_pin_cell.sv
// One pin's output driver: selects data and enable, applies open-drain.
// Assumes the caller has already chosen between port and peripheral function.
`default_nettype none
module sbio_pin_cell (
  input  wire logic periph_sel,
  input  wire logic periph_drive,
  input  wire logic periph_data,
  input  wire logic dir_bit,
  input  wire logic latch_bit,
  input  wire logic drain_bit,
  output logic      pin_out,
  output logic      pin_oe
);
  logic drive;
  logic data;
  always_comb begin
    drive = periph_sel ? periph_drive : dir_bit;
    data  = periph_sel ? periph_data : latch_bit;
    // Open drain: high-side off, so a one is released rather than driven.
    pin_out = data;
    pin_oe  = drive && !(drain_bit && data);
  end
endmodule : sbio_pin_cell
`default_nettype wire

// file: hw/sbio_pin_mux.sv
// Pin multiplexer for the six shared pins.
// Assumes registered configuration on the interface; output is combinational.
`default_nettype none
module sbio_pin_mux
  import sbio_pkg::*;
(
  sbio_cfg_if.mux   cfg,
  input  wire logic sck_out_ch0,
  input  wire logic sck_out_ch1,
  input  wire logic txd_ch0,
  input  wire logic txd_ch1,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] periph_in
);
  logic [5:0] sel;
  logic [5:0] pdrive;
  logic [5:0] pdata;
  logic       clock_enable_0_0, clock_enable_1_0, ca_0, clock_enable_0_1, clock_enable_1_1, ca_1;

  always_comb begin
    clock_enable_0_0 = cfg.serial_ctrl[SBIO_SC_CLOCK_ENABLE_0_CH0];
    clock_enable_1_0 = cfg.serial_ctrl[SBIO_SC_CLOCK_ENABLE_1_CH0];
    ca_0   = cfg.serial_ctrl[SBIO_SC_CA_CH0];
    clock_enable_0_1 = cfg.serial_ctrl[SBIO_SC_CLOCK_ENABLE_0_CH1];
    clock_enable_1_1 = cfg.serial_ctrl[SBIO_SC_CLOCK_ENABLE_1_CH1];
    ca_1   = cfg.serial_ctrl[SBIO_SC_CA_CH1];
    // No operating-mode input exists; selection is the same in every mode.
    sel[5]    = clock_enable_1_1 || ca_1 || clock_enable_0_1;
    pdrive[5] = !clock_enable_1_1;
    pdata[5]  = sck_out_ch1;
    sel[4]    = clock_enable_1_0 || ca_0 || clock_enable_0_0;
    pdrive[4] = !clock_enable_1_0;
    pdata[4]  = sck_out_ch0;
    sel[3]    = cfg.serial_ctrl[SBIO_SC_RE_CH1];
    pdrive[3] = 1'b0;
    pdata[3]  = 1'b0;
    sel[2]    = cfg.serial_ctrl[SBIO_SC_RE_CH0];
    pdrive[2] = 1'b0;
    pdata[2]  = 1'b0;
    sel[1]    = cfg.serial_ctrl[SBIO_SC_TE_CH1];
    pdrive[1] = 1'b1;
    pdata[1]  = txd_ch1;
    sel[0]    = cfg.serial_ctrl[SBIO_SC_TE_CH0];
    pdrive[0] = 1'b1;
    pdata[0]  = txd_ch0;
  end

  for (genvar i = 0; i < SBIO_PINS; i++) begin : g_cell
    sbio_pin_cell u_cell (
      .periph_sel   (sel[i]),
      .periph_drive (pdrive[i]),
      .periph_data  (pdata[i]),
      .dir_bit      (cfg.direction[i]),
      .latch_bit    (cfg.latch[i]),
      .drain_bit    (cfg.drain[i]),
      .pin_out      (pin_out[i]),
      .pin_oe       (pin_oe[i])
    );
  end
  assign periph_in = '0;
endmodule : sbio_pin_mux
`default_nettype wire

// file: hw/sbio_port.sv
// Top of the six-bit shared I/O port: AHB-Lite slave, registers, pin outputs.
// Assumes pins and serial-channel signals are synchronous to hclk.
//
// Summary of operation
// - Six I/O pins, mode-independent function selection.
// - Same pin behaviour in every operating mode.
// - Direction one drives latch; zero is input.
// - Direction register write-only; reads undefined.
// - Direction clears on reset, standby; kept otherwise.
// - Output latch readable, writable, drives output pins.
// - Output latch clears on reset and standby.
// - Bits seven, six reserved; writes ignored.
// - Readback: latch when output, pin when input.
// - Readback register read-only; writes ignored.
// - Drain bit one gives open-drain output.
// - Drain bits clear on reset and standby.
// - Released serial pins revert to port control.
// - Pin five: port, clock out, clock in.
// - Pin four mirrors pin five for channel zero.
// - Pins one, zero become transmit outputs.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module sbio_port
  import sbio_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hw_standby,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe,
  input  wire logic        sck_out_ch0,
  input  wire logic        sck_out_ch1,
  input  wire logic        txd_ch0,
  input  wire logic        txd_ch1,
  output logic             serial_clock_ch0,
  output logic             serial_clock_ch1,
  output logic             receive_in_ch0,
  output logic             receive_in_ch1,
  output logic             interrupt_request_4,
  output logic             interrupt_request_5
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic        wr_pend;
    logic [2:0]  wr_sel;
    logic [5:0]  direction;
    logic [5:0]  latch;
    logic [5:0]  drain;
    logic [12:0] serial_ctrl;
    logic [31:0] rdata;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    logic [5:0]  pin_in;
  } sbio_state_s;

  localparam logic [2:0] SEL_NONE = 3'd0;
  localparam logic [2:0] SEL_DIR  = 3'd1;
  localparam logic [2:0] SEL_LAT  = 3'd2;
  localparam logic [2:0] SEL_ODR  = 3'd3;
  localparam logic [2:0] SEL_SC   = 3'd4;

  sbio_state_s st_r;
  sbio_state_s st_nxt;
  sbio_cfg_if  cfg ();
  logic [5:0]  mux_out;
  logic [5:0]  mux_oe;
  logic        take;
  logic [15:0] idx;
  logic [5:0]  readback;

  assign cfg.direction   = st_r.direction;
  assign cfg.latch       = st_r.latch;
  assign cfg.drain       = st_r.drain;
  assign cfg.serial_ctrl = st_r.serial_ctrl;

  // When a channel drops its enables the mux falls back to the registers.
  sbio_pin_mux u_mux (
    .cfg         (cfg.mux),
    .sck_out_ch0 (sck_out_ch0),
    .sck_out_ch1 (sck_out_ch1),
    .txd_ch0     (txd_ch0),
    .txd_ch1     (txd_ch1),
    .pin_out     (mux_out),
    .pin_oe      (mux_oe),
    .periph_in   ()
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    st_nxt = st_r;
    take   = hsel && hready && (htrans == SBIO_HTRANS_NONSEQ);
    idx    = haddr[SBIO_ADDR_W-1:2];
    // Readback: latch for output pins, sampled pin level for inputs.
    readback = (st_r.direction & st_r.latch) | (~st_r.direction & st_r.pin_in);

    if (st_r.wr_pend) begin
      st_nxt.wr_pend = 1'b0;
      case (st_r.wr_sel)
        SEL_DIR: st_nxt.direction   = hwdata[5:0];
        SEL_LAT: st_nxt.latch       = hwdata[5:0];
        SEL_ODR: st_nxt.drain       = hwdata[5:0];
        SEL_SC:  st_nxt.serial_ctrl = hwdata[12:0] & SBIO_SC_MASK;
        default: ;
      endcase
    end

    if (take) begin
      st_nxt.wr_sel = SEL_NONE;
      if (hwrite) begin
        st_nxt.wr_pend = 1'b1;
        case (idx)
          SBIO_IDX_PIN_DIRECTION: st_nxt.wr_sel = SEL_DIR;
          SBIO_IDX_OUTPUT_LATCH:  st_nxt.wr_sel = SEL_LAT;
          SBIO_IDX_DRAIN_SELECT:  st_nxt.wr_sel = SEL_ODR;
          SBIO_IDX_SERIAL_CTRL:   st_nxt.wr_sel = SEL_SC;
          default:                st_nxt.wr_sel = SEL_NONE;
        endcase
      end else begin
        case (idx)
          SBIO_IDX_PIN_DIRECTION:      st_nxt.rdata = SBIO_UNDEF_WORD;
          SBIO_IDX_OUTPUT_LATCH:       st_nxt.rdata = {26'd0, st_r.latch};
          SBIO_IDX_PIN_LEVEL_READBACK: st_nxt.rdata = {26'd0, readback};
          SBIO_IDX_DRAIN_SELECT:       st_nxt.rdata = {26'd0, st_r.drain};
          SBIO_IDX_SERIAL_CTRL:        st_nxt.rdata = {19'd0, st_r.serial_ctrl};
          default:                     st_nxt.rdata = SBIO_UNDEF_WORD;
        endcase
      end
    end

    // Hardware standby clears like reset; there is no software standby input,
    // so state is simply retained while the clock keeps running.
    if (hw_standby) begin
      st_nxt.direction   = SBIO_RST_BITS;
      st_nxt.latch       = SBIO_RST_BITS;
      st_nxt.drain       = SBIO_RST_BITS;
      st_nxt.serial_ctrl = SBIO_RST_SC;
    end

    st_nxt.pin_out = mux_out;
    st_nxt.pin_oe  = mux_oe;
    st_nxt.pin_in  = pin_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // The extra output flop delays pin changes by one cycle but keeps every
  // top-level output except the constant hreadyout and hresp registered.
  assign hrdata              = st_r.rdata;
  assign hreadyout           = 1'b1;  // constant, not a flop: zero-wait slave
  assign hresp               = 1'b0;
  assign pin_out             = st_r.pin_out;
  assign pin_oe              = st_r.pin_oe;
  assign serial_clock_ch1    = st_r.pin_in[5];
  assign serial_clock_ch0    = st_r.pin_in[4];
  assign receive_in_ch1      = st_r.pin_in[3];
  assign receive_in_ch0      = st_r.pin_in[2];
  assign interrupt_request_5 = st_r.pin_in[5];
  assign interrupt_request_4 = st_r.pin_in[4];

endmodule : sbio_port
`default_nettype wire

// file: inc/sbio_cfg_if.sv
// Interface carrying the configuration of the pin multiplexer.
// Assumes one driver (the register file) and one reader (the pin mux).
`default_nettype none
interface sbio_cfg_if;
  logic [5:0]  direction;
  logic [5:0]  latch;
  logic [5:0]  drain;
  logic [12:0] serial_ctrl;
  modport regs (output direction, output latch, output drain, output serial_ctrl);
  modport mux  (input direction, input latch, input drain, input serial_ctrl);
endinterface : sbio_cfg_if
`default_nettype wire

// file: inc/sbio_pkg.sv
// Package for the six-bit shared I/O port: register map, field layout, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`default_nettype none
package sbio_pkg;
  localparam int unsigned SBIO_PINS = 6;

  // Byte addresses: all printed offsets are even but not all are multiples of four,
  // so each printed offset is a register index and the byte address is four times it.
  localparam logic [15:0] SBIO_IDX_PIN_DIRECTION      = 16'hfeb2;
  localparam logic [15:0] SBIO_IDX_PIN_LEVEL_READBACK = 16'hff52;
  localparam logic [15:0] SBIO_IDX_OUTPUT_LATCH       = 16'hff62;
  localparam logic [15:0] SBIO_IDX_DRAIN_SELECT       = 16'hff76;
  localparam logic [15:0] SBIO_IDX_SERIAL_CTRL        = 16'hff80;
  localparam int unsigned SBIO_ADDR_W                 = 18;

  // Serial control register fields (loose bits gathered into one register).
  localparam int unsigned SBIO_SC_CLOCK_ENABLE_0_CH0 = 0;
  localparam int unsigned SBIO_SC_CLOCK_ENABLE_1_CH0 = 1;
  localparam int unsigned SBIO_SC_CA_CH0   = 2;
  localparam int unsigned SBIO_SC_TE_CH0   = 3;
  localparam int unsigned SBIO_SC_RE_CH0   = 4;
  localparam int unsigned SBIO_SC_CLOCK_ENABLE_0_CH1 = 8;
  localparam int unsigned SBIO_SC_CLOCK_ENABLE_1_CH1 = 9;
  localparam int unsigned SBIO_SC_CA_CH1   = 10;
  localparam int unsigned SBIO_SC_TE_CH1   = 11;
  localparam int unsigned SBIO_SC_RE_CH1   = 12;
  localparam logic [12:0] SBIO_SC_MASK     = 13'h1f1f;

  localparam logic [5:0]  SBIO_RST_BITS    = 6'h00;
  localparam logic [12:0] SBIO_RST_SC      = 13'h0000;
  // Value returned for the write-only and reserved fields; arbitrary but fixed.
  localparam logic [31:0] SBIO_UNDEF_WORD  = 32'h0000_0000;

  localparam logic [1:0]  SBIO_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0]  SBIO_HSIZE_WORD    = 3'b010;
endpackage : sbio_pkg
`default_nettype wire

// file: tb/sbio_board.sv
// Board model for the six shared pins: far-side drivers and pull-ups.
// Assumes the port drives a pin only while its enable is high.
`default_nettype none
module sbio_board (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  output logic      [5:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Wire resolution
  // ****
  // An undriven pin floats to the pull-up, so an open-drain high reads one.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~(ext_en & ~ext_val));
endmodule // sbio_board
`default_nettype wire

// file: tb/sbio_monitor.sv
// Checker for the six-bit shared I/O port, on its top-level ports.
// Assumes a bind into sbio_port from the bench's top file.
`default_nettype none
module sbio_monitor
  import sbio_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hw_standby,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [5:0]  pin_in,
  input wire logic [5:0]  pin_out,
  input wire logic [5:0]  pin_oe,
  input wire logic        serial_clock_ch0,
  input wire logic        serial_clock_ch1,
  input wire logic        receive_in_ch0,
  input wire logic        receive_in_ch1,
  input wire logic        interrupt_request_4,
  input wire logic        interrupt_request_5
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled");
  // The serial control word reaches bit 12; the port registers stop at bit 5.
  property p_high; hrdata[31:13] == 19'h0_0000 && hrdata[7:6] == 2'b00; endproperty
  a_high: assert property (p_high) else $error("high read bits set");
  property p_hold;
    !(hsel && hready && !hwrite && htrans == SBIO_HTRANS_NONSEQ) |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_irq;
    $past(hresetn) |-> {interrupt_request_5, interrupt_request_4} == $past(pin_in[5:4]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq copy wrong");
  property p_sck;
    $past(hresetn) |-> {serial_clock_ch1, serial_clock_ch0} == $past(pin_in[5:4]);
  endproperty
  a_sck: assert property (p_sck) else $error("clock copy wrong");
  property p_rx;
    $past(hresetn) |-> {receive_in_ch1, receive_in_ch0} == $past(pin_in[3:2]);
  endproperty
  a_rx: assert property (p_rx) else $error("receive copy wrong");
  property p_stby; hw_standby |-> ##2 pin_oe == 6'h00; endproperty
  a_stby: assert property (p_stby) else $error("standby left drivers on");
  property p_rst; $rose(hresetn) |-> pin_oe == 6'h00 && pin_out == 6'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset left pins driven");
  c_stby: cover property (hw_standby);
  c_read: cover property (hsel && !hwrite && htrans == SBIO_HTRANS_NONSEQ);
  c_pin5: cover property ($rose(pin_oe[5]));
endmodule // sbio_monitor
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the six-bit shared I/O port.
// Assumes one AHB-Lite slave whose hreadyout is also the bus hready.
`default_nettype none
module testbench
  import sbio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_DIR = SBIO_IDX_PIN_DIRECTION;
  localparam logic [15:0] A_RB  = SBIO_IDX_PIN_LEVEL_READBACK;
  localparam logic [15:0] A_LAT = SBIO_IDX_OUTPUT_LATCH;
  localparam logic [15:0] A_OD  = SBIO_IDX_DRAIN_SELECT;
  localparam logic [15:0] A_SC  = SBIO_IDX_SERIAL_CTRL;
  logic        hclk, hresetn, hw_standby, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0]  pin_in, pin_out, pin_oe, ext_val, ext_en;
  logic        sck_out_ch0, sck_out_ch1, txd_ch0, txd_ch1;
  logic        serial_clock_ch0, serial_clock_ch1, receive_in_ch0, receive_in_ch1;
  logic        interrupt_request_4, interrupt_request_5;
  int          bad_count, num_checks;
  sbio_port dut (.hclk, .hresetn, .hw_standby, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe,
    .sck_out_ch0, .sck_out_ch1, .txd_ch0, .txd_ch1, .serial_clock_ch0, .serial_clock_ch1,
    .receive_in_ch0, .receive_in_ch1, .interrupt_request_4, .interrupt_request_5);
  sbio_board board (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'b00};
    htrans <= SBIO_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [5:0] exp);
    bus(idx, 1'b0, 16'h0000);
    chk(rd, {26'h000_0000, exp});
  endtask
  // Pins follow a register write one edge after it commits.
  task automatic pchk(input logic [5:0] oe, input logic [5:0] out);
    @(posedge hclk);
    #1;
    chk({20'h0_0000, pin_oe, pin_out & pin_oe}, {20'h0_0000, oe, out});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****
  // Clock, watchdog, tests
  // ****
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // The tests need some 120 cycles; reaching the 2000-cycle limit means a hang.
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  initial begin
    {hresetn, hw_standby, hsel, hwrite, sck_out_ch0, sck_out_ch1, txd_ch0, txd_ch1} = 8'h00;
    htrans = 2'b00;
    hsize = SBIO_HSIZE_WORD;
    haddr = '0;
    hwdata = '0;
    ext_val = 6'h2a;
    ext_en = 6'h3f;
    bad_count = 0;
    num_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(A_LAT, 6'h00);
    rdc(A_OD, 6'h00);
    rdc(A_RB, 6'h2a);
    pchk(6'h00, 6'h00);
    wr(A_DIR, 16'h00ff);
    wr(A_LAT, 16'h00d5);
    rdc(A_LAT, 6'h15);
    pchk(6'h3f, 6'h15);
    rdc(A_RB, 6'h15);
    wr(A_DIR, 16'h000f);
    // A released pin reaches the readback only two edges after the direction
    // commits: one edge for the output flop, one for the input flop.
    @(posedge hclk);
    rdc(A_RB, 6'h25);
    rdc(A_DIR, 6'h00);
    wr(A_RB, 16'h003f);
    wr(16'h0001, 16'h003f);
    rdc(16'h0001, 6'h00);
    rdc(A_LAT, 6'h15);
    rdc(A_RB, 6'h25);
    wr(A_OD, 16'h00ff);
    rdc(A_OD, 6'h3f);
    pchk(6'h0a, 6'h00);
    wr(A_OD, 16'h0000);
    wr(A_DIR, 16'h003f);
    // Channel levels differ from the latch bits, so a missed selection shows.
    sck_out_ch1 <= 1'b1;
    txd_ch1 <= 1'b1;
    wr(A_SC, 16'h1c1a);
    pchk(6'h23, 6'h22);
    bus(A_SC, 1'b0, 16'h0000);
    chk(rd, 32'h0000_1c1a);
    wr(A_SC, 16'h0000);
    pchk(6'h3f, 6'h15);
    wr(A_SC, 16'h0101);
    pchk(6'h3f, 6'h25);
    wr(A_SC, 16'h0404);
    pchk(6'h3f, 6'h25);
    wr(A_SC, 16'h0202);
    pchk(6'h0f, 6'h05);
    wr(A_SC, 16'h0000);
    wr(A_DIR, 16'h0000);
    ext_val <= 6'h1c;
    repeat (2) @(posedge hclk);
    #1;
    chk({26'h000_0000, interrupt_request_5, interrupt_request_4, serial_clock_ch1,
      serial_clock_ch0, receive_in_ch1, receive_in_ch0}, 32'h0000_0017);
    rdc(A_RB, 6'h1c);
    wr(A_DIR, 16'h003f);
    wr(A_OD, 16'h003f);
    @(posedge hclk);
    hw_standby <= 1'b1;
    @(posedge hclk);
    hw_standby <= 1'b0;
    rdc(A_LAT, 6'h00);
    rdc(A_OD, 6'h00);
    pchk(6'h00, 6'h00);
    wr(A_LAT, 16'h003f);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rdc(A_LAT, 6'h00);
    conclude();
  end
endmodule // testbench
bind sbio_port sbio_monitor mon (.hclk, .hresetn, .hw_standby, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .serial_clock_ch0,
  .serial_clock_ch1, .receive_in_ch0, .receive_in_ch1, .interrupt_request_4,
  .interrupt_request_5);
`default_nettype wire
